// [logic/clk_ctrl_pkg.sv]
package clk_ctrl_pkg;

  // Oscillator selection encoding
  localparam logic [2:0] SRC_FRC       = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL   = 3'h1;
  localparam logic [2:0] SRC_PRI       = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL   = 3'h3;
  localparam logic [2:0] SRC_SEC       = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC      = 3'h5;
  localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
  localparam logic [2:0] SRC_FRC_DIVN  = 3'h7;

  // Primary submodes, fixed by configuration
  localparam logic [1:0] SUB_EC = 2'h0;
  localparam logic [1:0] SUB_XT = 2'h1;
  localparam logic [1:0] SUB_HS = 2'h2;

  // New-clock cycles counted before the handover
  localparam int         SETTLE_CYCLES = 10;
  localparam logic [3:0] SETTLE_LAST   = 4'(SETTLE_CYCLES - 1);
  localparam logic [3:0] SETTLE_ZERO   = 4'h0;

  // Cycles that an unlock keeps the control register writable
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
  localparam logic [2:0] UNLOCK_NONE   = 3'h0;

  typedef enum logic [4:0] {
    SW_IDLE   = 5'h01,
    SW_CHECK  = 5'h02,
    SW_START  = 5'h04,
    SW_WAIT   = 5'h08,
    SW_SETTLE = 5'h10
  } sw_state_t;

  typedef enum logic [3:0] {
    PM_RUN   = 4'h1,
    PM_ENTER = 4'h2,
    PM_SLEEP = 4'h4,
    PM_IDLE  = 4'h8
  } pm_state_t;

  typedef struct packed {
    logic fast_rc;
    logic primary;
    logic secondary;
    logic low_power_rc;
    logic pll;
  } osc_enables_t;

  typedef struct packed {
    logic [2:0] current_source_sel;
    logic [2:0] new_source_sel;
    logic       switch_request;
    logic       pll_lock_flag;
    logic       clock_fail_flag;
    logic       secondary_osc_enable;
  } osc_status_t;

  typedef struct packed {
    logic switch_request;
    logic secondary_osc_enable;
    logic clock_fail_keep;
  } osc_low_wr_t;

  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
  endfunction : uses_pll

  // Crystal sources must wait for the start-up timer; external clock need not
  function automatic logic needs_ost(input logic [2:0] src, input logic [1:0] sub);
    needs_ost = (src == SRC_SEC) || (((src == SRC_PRI) || (src == SRC_PRI_PLL)) && (sub != SUB_EC));
  endfunction : needs_ost

  function automatic osc_enables_t enables_of(input logic [2:0] src);
    osc_enables_t e;
    e              = '0;
    e.fast_rc      = (src == SRC_FRC) || (src == SRC_FRC_PLL) || (src == SRC_FRC_DIV16) || (src == SRC_FRC_DIVN);
    e.primary      = (src == SRC_PRI) || (src == SRC_PRI_PLL);
    e.secondary    = (src == SRC_SEC);
    e.low_power_rc = (src == SRC_LOW_POWER_RC_OSC);
    e.pll          = uses_pll(src);
    enables_of     = e;
  endfunction : enables_of

endpackage : clk_ctrl_pkg

// [logic/pin_sync3.sv]
`timescale 1ns/10ps
module pin_sync3
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Asynchronous level in, filtered level out
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // The output moves only once stages two and three agree
  always_comb begin
    state_next    = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2 == state_reg.s3) begin
      state_next.q = state_reg.s2;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.q;

endmodule : pin_sync3

// [logic/unlock_guard.sv]
`timescale 1ns/10ps
module unlock_guard
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Unlock sequence completed, and control register writes
  input  wire logic unlock_done,
  input  wire logic wr_high,
  input  wire logic wr_low,
  // Write may take effect this cycle
  output logic      write_ok
);

  typedef struct packed {
    logic [2:0] window;
  } unlock_state_t;

  unlock_state_t state_reg;
  unlock_state_t state_next;

  // Any write closes the window unless an unlock comes in the same cycle, so each byte needs its own unlock
  always_comb begin
    state_next = state_reg;
    if (unlock_done) begin
      state_next.window = UNLOCK_WINDOW;
    end else if (wr_high || wr_low) begin
      state_next.window = UNLOCK_NONE;
    end else if (state_reg.window != UNLOCK_NONE) begin
      state_next.window = state_reg.window - 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign write_ok = (state_reg.window != UNLOCK_NONE);

endmodule : unlock_guard

// [logic/clock_switch_power_save_ctrl.sv]
`timescale 1ns/10ps
module clock_switch_power_save_ctrl
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // Configuration
  input  wire logic         switch_monitor_cfg_bit,
  input  wire logic [2:0]   initial_source_cfg,
  input  wire logic [1:0]   primary_submode_cfg,
  input  wire logic         watchdog_enable,
  // Software access to the oscillator control register
  input  wire logic         unlock_done,
  input  wire logic         wr_high,
  input  wire logic [2:0]   wr_new_source,
  input  wire logic         wr_low,
  input  wire osc_low_wr_t  wr_low_data,
  output osc_status_t       osc_control_reg,
  // Oscillator and PLL pins
  input  wire logic         startup_timer_done,
  input  wire logic         pll_locked,
  input  wire logic         new_clk_probe,
  input  wire logic         osc_failed,
  output logic              startup_timer_start,
  output osc_enables_t      osc_enable,
  output logic [1:0]        primary_submode,
  output logic [2:0]        sys_clk_select,
  // Fail-safe monitor
  output logic              failsafe_monitor_active,
  output logic              clock_fail_trap,
  // Power save
  input  wire logic         power_save_instruction,
  input  wire logic         power_save_sleep,
  input  wire logic         irq_wake,
  input  wire logic         watchdog_timeout,
  output logic              watchdog_clear,
  output logic              cpu_clk_run,
  output logic              sys_clk_run,
  output logic              wake_pulse
);

  typedef struct packed {
    sw_state_t  sw;
    pm_state_t  pm;
    logic [2:0] cur;
    logic [2:0] nxt;
    logic       req;
    logic       lock;
    logic       fail;
    logic       sec_en;
    logic       sleep_sel;
    logic [3:0] settle;
    logic       tick_q;
    logic       fail_q;
    logic       trap;
    logic       wdt_clr;
    logic       wake;
    logic       ost_start;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  logic         write_ok;
  logic         ost_s;
  logic         lock_s;
  logic         tick_s;
  logic         fail_s;
  logic         switch_on;
  logic         monitor_on;
  logic         tick_rise;
  logic         fail_rise;
  logic         target_ready;
  logic [2:0]   fallback;
  osc_enables_t en;

  unlock_guard u_unlock (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .unlock_done (unlock_done),
    .wr_high     (wr_high),
    .wr_low      (wr_low),
    .write_ok    (write_ok)
  );

  pin_sync3 u_sync_ost (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (startup_timer_done),
    .sync_out (ost_s)
  );

  pin_sync3 u_sync_lock (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (pll_locked),
    .sync_out (lock_s)
  );

  // The new clock is sampled, so it must run well below half of clk_sys
  pin_sync3 u_sync_tick (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (new_clk_probe),
    .sync_out (tick_s)
  );

  pin_sync3 u_sync_fail (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (osc_failed),
    .sync_out (fail_s)
  );

  assign switch_on    = ~switch_monitor_cfg_bit;
  assign monitor_on   = ~switch_monitor_cfg_bit;
  assign tick_rise    = tick_s & ~state_reg.tick_q;
  assign fail_rise    = fail_s & ~state_reg.fail_q;
  assign target_ready = (~needs_ost(state_reg.nxt, primary_submode_cfg) | ost_s) &
                        (~uses_pll(state_reg.nxt) | lock_s);
  assign fallback     = uses_pll(state_reg.cur) ? SRC_FRC_PLL : SRC_FRC;

  always_comb begin
    state_next           = state_reg;
    state_next.trap      = 1'b0;
    state_next.wdt_clr   = 1'b0;
    state_next.wake      = 1'b0;
    state_next.ost_start = 1'b0;
    state_next.tick_q    = tick_s;
    state_next.fail_q    = fail_s;

    // High byte: new source, only while no switch is in flight
    if (wr_high && write_ok && state_reg.sw == SW_IDLE) begin
      state_next.nxt = wr_new_source;
    end

    // Low byte: secondary enable, fail flag clear, switch request
    if (wr_low && write_ok) begin
      state_next.sec_en = wr_low_data.secondary_osc_enable;
      if (!wr_low_data.clock_fail_keep) begin
        state_next.fail = 1'b0;
      end
      if (switch_on && wr_low_data.switch_request && state_reg.sw == SW_IDLE) begin
        state_next.req = 1'b1;
        state_next.sw  = SW_CHECK;
      end
    end

    unique case (state_reg.sw)
      SW_IDLE: begin
      end
      SW_CHECK: begin
        if (state_reg.cur == state_reg.nxt) begin
          state_next.req = 1'b0;
          state_next.sw  = SW_IDLE;
        end else begin
          state_next.lock      = 1'b0;
          state_next.fail      = 1'b0;
          state_next.ost_start = needs_ost(state_reg.nxt, primary_submode_cfg);
          state_next.sw        = SW_START;
        end
      end
      SW_START: begin
        // One cycle for the enable to reach the target oscillator
        state_next.sw = SW_WAIT;
      end
      SW_WAIT: begin
        state_next.settle = SETTLE_ZERO;
        if (target_ready) begin
          state_next.sw = SW_SETTLE;
        end
      end
      SW_SETTLE: begin
        if (tick_rise) begin
          if (state_reg.settle == SETTLE_LAST) begin
            state_next.cur = state_reg.nxt;
            state_next.req = 1'b0;
            state_next.sw  = SW_IDLE;
          end else begin
            state_next.settle = state_reg.settle + 4'h1;
          end
        end
      end
    endcase

    // Lock flag is set by the detector while the target uses the PLL, except on the cycle a switch clears it
    if (lock_s && uses_pll(state_reg.nxt) && state_reg.sw != SW_CHECK) begin
      state_next.lock = 1'b1;
    end

    // A failure wins over any software clear or pending switch
    if (monitor_on && fail_rise && state_reg.pm != PM_SLEEP) begin
      state_next.fail = 1'b1;
      state_next.trap = 1'b1;
      state_next.cur  = fallback;
      state_next.nxt  = fallback;
      state_next.req  = 1'b0;
      state_next.sw   = SW_IDLE;
    end

    // Switching disabled: configuration owns the clock selection
    if (!switch_on) begin
      state_next.cur = initial_source_cfg;
      state_next.nxt = initial_source_cfg;
      state_next.req = 1'b0;
      state_next.sw  = SW_IDLE;
    end

    unique case (state_reg.pm)
      PM_RUN: begin
        if (power_save_instruction) begin
          state_next.sleep_sel = power_save_sleep;
          state_next.wdt_clr   = watchdog_enable;
          state_next.pm        = PM_ENTER;
        end
      end
      PM_ENTER: begin
        // Wake sources are not looked at until entry has completed
        state_next.pm = state_reg.sleep_sel ? PM_SLEEP : PM_IDLE;
      end
      PM_SLEEP, PM_IDLE: begin
        if (irq_wake || watchdog_timeout) begin
          state_next.wake = 1'b1;
          state_next.pm   = PM_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg           <= '0;
      state_reg.sw        <= SW_IDLE;
      state_reg.pm        <= PM_RUN;
      state_reg.cur       <= initial_source_cfg;
      state_reg.nxt       <= initial_source_cfg;
    end else begin
      state_reg <= state_next;
    end
  end

  // Oscillator enables: current source, plus target while switching
  always_comb begin
    en = enables_of(state_reg.cur);
    if (state_reg.sw == SW_START || state_reg.sw == SW_WAIT || state_reg.sw == SW_SETTLE) begin
      en = en | enables_of(state_reg.nxt);
    end
    en.secondary    = en.secondary | state_reg.sec_en;
    en.low_power_rc = en.low_power_rc | watchdog_enable | monitor_on;
    if (state_reg.pm == PM_SLEEP) begin
      en              = '0;
      en.secondary    = state_reg.sec_en;
      en.low_power_rc = watchdog_enable;
    end
  end

  assign osc_enable              = en;
  assign primary_submode         = primary_submode_cfg;
  assign sys_clk_select          = state_reg.cur;
  assign startup_timer_start     = state_reg.ost_start;
  assign failsafe_monitor_active = monitor_on & (state_reg.pm != PM_SLEEP);
  assign clock_fail_trap         = state_reg.trap;
  assign watchdog_clear          = state_reg.wdt_clr;
  assign wake_pulse              = state_reg.wake;
  assign cpu_clk_run             = (state_reg.pm == PM_RUN);
  assign sys_clk_run             = (state_reg.pm != PM_SLEEP);

  always_comb begin
    osc_control_reg                      = '0;
    osc_control_reg.current_source_sel   = state_reg.cur;
    osc_control_reg.new_source_sel       = state_reg.nxt;
    osc_control_reg.switch_request       = state_reg.req;
    osc_control_reg.pll_lock_flag        = state_reg.lock;
    osc_control_reg.clock_fail_flag      = state_reg.fail;
    osc_control_reg.secondary_osc_enable = state_reg.sec_en;
  end

endmodule : clock_switch_power_save_ctrl

// [bench/clock_switch_power_save_ctrl_sva.sv]
`timescale 1ns/10ps
module clock_switch_power_save_ctrl_chk
  import clk_ctrl_pkg::*;
(
  // Clock, reset and configuration
  input wire logic         clk_sys,
  input wire logic         rst_b,
  input wire logic         switch_monitor_cfg_bit,
  input wire logic [2:0]   initial_source_cfg,
  input wire logic         watchdog_enable,
  // Clock status
  input wire osc_status_t  osc_control_reg,
  input wire osc_enables_t osc_enable,
  input wire logic         failsafe_monitor_active,
  // Power save
  input wire logic         power_save_instruction,
  input wire logic         power_save_sleep,
  input wire logic         irq_wake,
  input wire logic         watchdog_timeout,
  input wire logic         watchdog_clear,
  input wire logic         cpu_clk_run,
  input wire logic         sys_clk_run,
  input wire logic         wake_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    power_save_instruction && cpu_clk_run;
  endsequence
  sequence s_enter;
    !cpu_clk_run && sys_clk_run;
  endsequence

  // Config is a level, so allow the registers one edge to follow it
  property p_off_req;
    switch_monitor_cfg_bit && $past(switch_monitor_cfg_bit) |-> !osc_control_reg.switch_request;
  endproperty
  a_off_req: assert property (p_off_req) else $error("request set while off");
  property p_off_src;
    switch_monitor_cfg_bit && $past(switch_monitor_cfg_bit) |-> osc_control_reg.current_source_sel == initial_source_cfg;
  endproperty
  a_off_src: assert property (p_off_src) else $error("source differs from config");
  property p_off_mon;
    switch_monitor_cfg_bit |-> !failsafe_monitor_active;
  endproperty
  a_off_mon: assert property (p_off_mon) else $error("monitor active while off");
  property p_idle;
    s_take ##0 !power_save_sleep |=> s_enter [*2];
  endproperty
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  property p_sleep;
    s_take ##0 power_save_sleep |=> s_enter ##1 (!sys_clk_run && !failsafe_monitor_active);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_wdclr;
    s_take ##0 watchdog_enable |=> watchdog_clear;
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("watchdog not cleared");
  property p_defer;
    !cpu_clk_run && $past(cpu_clk_run) |=> !cpu_clk_run;
  endproperty
  a_defer: assert property (p_defer) else $error("woke before entry done");
  property p_wake;
    !cpu_clk_run && !$past(cpu_clk_run) && (irq_wake || watchdog_timeout) |=> wake_pulse && cpu_clk_run;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_sleep_osc;
    !sys_clk_run |-> osc_enable.low_power_rc == watchdog_enable && !osc_enable.fast_rc && !osc_enable.primary;
  endproperty
  a_sleep_osc: assert property (p_sleep_osc) else $error("oscillators wrong in sleep");
  property p_low_power_rc_osc_run;
    !switch_monitor_cfg_bit && sys_clk_run |-> osc_enable.low_power_rc && failsafe_monitor_active;
  endproperty
  a_low_power_rc_osc_run: assert property (p_low_power_rc_osc_run) else $error("low-power rc off with monitor");
endmodule : clock_switch_power_save_ctrl_chk

bind clock_switch_power_save_ctrl clock_switch_power_save_ctrl_chk u_chk (
  .clk_sys, .rst_b, .switch_monitor_cfg_bit, .initial_source_cfg, .watchdog_enable, .osc_control_reg,
  .osc_enable, .failsafe_monitor_active, .power_save_instruction, .power_save_sleep, .irq_wake,
  .watchdog_timeout, .watchdog_clear, .cpu_clk_run, .sys_clk_run, .wake_pulse
);

// [bench/tb_clock_switch_power_save_ctrl.sv]
`timescale 1ns/10ps
module tb_clock_switch_power_save_ctrl
  import clk_ctrl_pkg::*;
;
  typedef struct packed {
    logic [2:0] src;
    logic       abort;
    logic       fail;
    logic [4:0] en;
  } row_t;

  logic         clk_sys = 1'h0, rst_b = 1'h0, cfg_bit = 1'h0, wdt_en = 1'h1, unlock = 1'h0, wr_hi = 1'h0;
  logic         wr_lo = 1'h0, st_done = 1'h0, locked = 1'h0, probe = 1'h0, failed = 1'h0, probe_on = 1'h0;
  logic         ps_instr = 1'h0, ps_sleep = 1'h0, irq = 1'h0, wdt_to = 1'h0;
  logic         mon_act, trap, cpu_run, sys_run, wake, ost_pulse;
  logic [2:0]   init_src = SRC_FRC, new_src = SRC_FRC, sel, div = 3'h0;
  logic [1:0]   sub = SUB_XT, psub;
  osc_low_wr_t  low_data = '0;
  osc_status_t  ctl;
  osc_enables_t en;
  int           fails = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  int           i;
  int           ost_cnt = 0;
  int           ost0 = 0;
  row_t         rows [10] = '{
    '{SRC_SEC, 1'h0, 1'h0, 5'h06}, '{SRC_LOW_POWER_RC_OSC, 1'h0, 1'h0, 5'h02},
    '{SRC_FRC_DIV16, 1'h0, 1'h0, 5'h12}, '{SRC_FRC_DIVN, 1'h0, 1'h0, 5'h12},
    '{SRC_PRI, 1'h0, 1'h1, 5'h0A}, '{SRC_PRI_PLL, 1'h0, 1'h1, 5'h0B},
    '{SRC_FRC, 1'h0, 1'h0, 5'h12}, '{SRC_FRC_PLL, 1'h0, 1'h0, 5'h13},
    '{SRC_FRC_PLL, 1'h1, 1'h0, 5'h13}, '{SRC_FRC, 1'h0, 1'h0, 5'h12}
  };

  clock_switch_power_save_ctrl dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .switch_monitor_cfg_bit(cfg_bit), .initial_source_cfg(init_src),
    .primary_submode_cfg(sub), .watchdog_enable(wdt_en), .unlock_done(unlock), .wr_high(wr_hi),
    .wr_new_source(new_src), .wr_low(wr_lo), .wr_low_data(low_data), .osc_control_reg(ctl),
    .startup_timer_done(st_done), .pll_locked(locked), .new_clk_probe(probe), .osc_failed(failed),
    .startup_timer_start(ost_pulse), .osc_enable(en), .primary_submode(psub), .sys_clk_select(sel),
    .failsafe_monitor_active(mon_act), .clock_fail_trap(trap), .power_save_instruction(ps_instr),
    .power_save_sleep(ps_sleep), .irq_wake(irq), .watchdog_timeout(wdt_to), .watchdog_clear(),
    .cpu_clk_run(cpu_run), .sys_clk_run(sys_run), .wake_pulse(wake)
  );

  always #2 clk_sys = ~clk_sys;

  // New oscillator held still until started, so its edge count has a known phase
  always @(posedge clk_sys) begin
    div <= probe_on ? div + 3'h1 : 3'h0;
    probe <= div[2];
    cyc <= cyc + 1;
    // Counted here so that a one-cycle start pulse is never missed between checks
    if (ost_pulse === 1'h1) begin
      ost_cnt <= ost_cnt + 1;
    end
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Unlock, then after gap idle cycles write one byte of the control register
  task automatic reg_write(input logic hi, input logic [2:0] src, input logic req, input int gap);
    @(posedge clk_sys);
    unlock <= 1'h1;
    @(posedge clk_sys);
    unlock <= 1'h0;
    repeat (gap) @(posedge clk_sys);
    wr_hi <= hi;
    wr_lo <= !hi;
    new_src <= src;
    low_data <= {req, 2'h1};
    @(posedge clk_sys);
    wr_hi <= 1'h0;
    wr_lo <= 1'h0;
  endtask : reg_write

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'h1;
    for (int r = 0; r < 10; r++) begin
      @(posedge clk_sys);
      failed <= 1'h0;
      ost0 = ost_cnt;
      st_done <= rows[r].abort;
      locked <= rows[r].abort;
      repeat (6) @(posedge clk_sys);
      reg_write(1'h1, rows[r].src, 1'h0, 0);
      reg_write(1'h0, 3'h0, 1'h1, 0);
      repeat (8) @(negedge clk_sys);
      chk("switch_request", !rows[r].abort, ctl.switch_request);
      if (!rows[r].abort) begin
        chk("pll_lock_flag", 1'h0, ctl.pll_lock_flag);
        chk("clock_fail_flag", 1'h0, ctl.clock_fail_flag);
        @(posedge clk_sys);
        st_done <= 1'h1;
        locked <= 1'h1;
        repeat (10) @(posedge clk_sys);
        probe_on <= 1'h1;
        for (i = 0; i < 200 && ctl.switch_request !== 1'h0; i++) @(negedge clk_sys);
        chk("settle_cycles", 1'h1, i >= 77 && i <= 88);
        @(posedge clk_sys);
        probe_on <= 1'h0;
      end
      @(negedge clk_sys);
      chk("switch_request", 1'h0, ctl.switch_request);
      chk("current_source_sel", rows[r].src, ctl.current_source_sel);
      chk("sys_clk_select", rows[r].src, sel);
      chk("osc_enable", rows[r].en, en);
      chk("startup_timer_start", !rows[r].abort && rows[r].src inside {SRC_SEC, SRC_PRI, SRC_PRI_PLL},
          8'(ost_cnt - ost0));
      chk("pll_lock_flag", rows[r].src inside {SRC_FRC_PLL, SRC_PRI_PLL}, ctl.pll_lock_flag);
      if (rows[r].fail) begin
        @(posedge clk_sys);
        failed <= 1'h1;
        for (i = 0; i < 10 && trap !== 1'h1; i++) @(negedge clk_sys);
        chk("clock_fail_trap", 1'h1, trap);
        @(negedge clk_sys);
        chk("current_source_sel", rows[r].src == SRC_PRI ? SRC_FRC : SRC_FRC_PLL, ctl.current_source_sel);
        chk("clock_fail_flag", 1'h1, ctl.clock_fail_flag);
      end
    end
    reg_write(1'h1, SRC_LOW_POWER_RC_OSC, 1'h0, 6);
    @(negedge clk_sys);
    chk("new_source_sel", SRC_FRC, ctl.new_source_sel);
    // External clock needs no start-up timer, so the switch must finish with the timer held off
    @(posedge clk_sys);
    sub <= SUB_EC;
    st_done <= 1'h0;
    probe_on <= 1'h1;
    ost0 = ost_cnt;
    reg_write(1'h1, SRC_PRI, 1'h0, 0);
    reg_write(1'h0, 3'h0, 1'h1, 0);
    repeat (8) @(negedge clk_sys);
    chk("switch_request", 1'h1, ctl.switch_request);
    for (i = 0; i < 200 && ctl.switch_request !== 1'h0; i++) @(negedge clk_sys);
    chk("switch_request", 1'h0, ctl.switch_request);
    chk("current_source_sel", SRC_PRI, ctl.current_source_sel);
    chk("startup_timer_start", 8'h0, 8'(ost_cnt - ost0));
    chk("primary_submode", sub, psub);
    @(posedge clk_sys);
    probe_on <= 1'h0;
    // Idle woken by interrupt, sleep by time-out, sleep with an interrupt already pending
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      ps_instr <= 1'h1;
      ps_sleep <= k != 0;
      irq <= k == 2;
      @(posedge clk_sys);
      ps_instr <= 1'h0;
      repeat (2) @(negedge clk_sys);
      chk("cpu_clk_run", 1'h0, cpu_run);
      chk("sys_clk_run", k == 0, sys_run);
      chk("osc_enable", k == 0 ? 5'h0A : 5'h02, en);
      @(posedge clk_sys);
      irq <= k != 1;
      wdt_to <= k == 1;
      for (i = 0; i < 6 && wake !== 1'h1; i++) @(negedge clk_sys);
      chk("wake_pulse", 1'h1, wake);
      @(posedge clk_sys);
      irq <= 1'h0;
      wdt_to <= 1'h0;
      @(negedge clk_sys);
      chk("cpu_clk_run", 1'h1, cpu_run);
      chk("sys_clk_select", SRC_PRI, sel);
    end
    @(posedge clk_sys);
    rst_b <= 1'h0;
    cfg_bit <= 1'h1;
    init_src <= SRC_PRI;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'h1;
    reg_write(1'h1, SRC_SEC, 1'h0, 0);
    reg_write(1'h0, 3'h0, 1'h1, 0);
    repeat (3) @(negedge clk_sys);
    chk("switch_request", 1'h0, ctl.switch_request);
    chk("current_source_sel", SRC_PRI, ctl.current_source_sel);
    chk("sys_clk_select", SRC_PRI, sel);
    chk("failsafe_monitor_active", 1'h0, mon_act);
    report_and_stop();
  end
endmodule : tb_clock_switch_power_save_ctrl
